// ==== bpg_regs.vh ====
`ifndef BPG_REGS_VH
`define BPG_REGS_VH

// register indices; byte address is four times the index
`define BPG_IDX_HIGH_DATA 8'h00
`define BPG_IDX_LOW_DATA  8'h01
`define BPG_IDX_HIGH_DIR  8'h02
`define BPG_IDX_LOW_DIR   8'h03
`define BPG_IDX_CTL_DATA  8'h08
`define BPG_IDX_CTL_DIR   8'h09
`define BPG_IDX_PIN_ASSGN 8'h0a
`define BPG_IDX_MODE      8'h0b
`define BPG_IDX_PULLUP    8'h0c
`define BPG_IDX_BASE      8'h11
`define BPG_IDX_EXP_LAST  8'h0f

// address decode: block occupies one 1 kbyte window
`define BPG_BASE_HI 15
`define BPG_BASE_LO 10
`define BPG_IDX_HI  9
`define BPG_IDX_LO  2

// mode register fields
`define BPG_MODE_EMUL 0
`define BPG_MODE_EXP 1
`define BPG_MODE_PER 2

// pin assignment fields
`define BPG_PA_NOACC 7
`define BPG_PA_PIPE  5
`define BPG_PA_NOECK 4
`define BPG_PA_LSTR  3
`define BPG_PA_RDW   2

// pull-up register field
`define BPG_PU_CTL 4

// reset values
`define BPG_RST_DIR    8'h00
`define BPG_RST_DATA   8'h00
`define BPG_RST_PA     8'h10
`define BPG_RST_MODE   8'h00
`define BPG_RST_PULLUP 8'h00
`define BPG_RST_BASE   6'h00

// control port bits that can never drive
`define BPG_CTL_IN_ONLY 8'h03

`endif

// ==== bpg_sync.v ====
module bpg_sync (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] pin_in,
  output reg  [7:0] pin_sync
);

  reg [7:0] stage1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule

// ==== bpg_top.v ====
// Functional notes
// R1: direction 1 drives pin, 0 floats it
// R2: read returns pin if input, latch if output
// R3: address/data port directions reset to zero
// R4: high port carries high address/data when expanded
// R5: low port carries low address/data when expanded
// R6: expanded mode hides address/data port registers
// R7: peripheral mode hides first sixteen registers
// R8: expanded with emulate bit hides control port
// R9: control pins 7-2 bidirectional, 1-0 input
// R10: control bits 1-0 never drive, stay readable
// R11: assignment picks function, direction only for gpio
// R12: one bit enables control port pull-ups
// R13: software waits two cycles before pin read
// R14: software loads data before enabling outputs
// R15: absolute address is base plus offset
// R16: alternate function overrides direction bit
// R17: pin inputs synchronised before read path
`include "bpg_regs.vh"

module bpg_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         ext_access,
  output reg         addr_data_bus_mode,
  output reg  [7:0]  ctl_alt_select,
  output reg         ctl_pullup_en,
  input  wire [7:0]  high_port_in,
  output reg  [7:0]  high_port_out,
  output reg  [7:0]  high_port_oe,
  input  wire [7:0]  low_port_in,
  output reg  [7:0]  low_port_out,
  output reg  [7:0]  low_port_oe,
  input  wire [7:0]  control_port_in,
  output reg  [7:0]  control_port_out,
  output reg  [7:0]  control_port_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] high_port_data;
  reg [7:0] low_port_data;
  reg [7:0] high_port_direction;
  reg [7:0] low_port_direction;
  reg [7:0] control_port_data;
  reg [7:0] control_port_direction;
  reg [7:0] control_pin_assignment;
  reg [7:0] mode_reg;
  reg [7:0] pullup_reg;
  reg [5:0] register_block_base;

  wire [7:0] high_sync;
  wire [7:0] low_sync;
  wire [7:0] ctl_sync;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // per-bit read source select
  function [7:0] port_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      port_read = (dir & latch) | (~dir & pin);
    end
  endfunction

  // on-chip visibility of an index under the current mode
  function reg_visible;
    input [7:0] idx;
    input       exp;
    input       per;
    input       emul;
    begin
      if (per && idx <= `BPG_IDX_EXP_LAST)
        reg_visible = 1'b0;
      else if (exp && idx <= `BPG_IDX_LOW_DIR)
        reg_visible = 1'b0;
      else if (exp && emul && (idx == `BPG_IDX_CTL_DATA || idx == `BPG_IDX_CTL_DIR))
        reg_visible = 1'b0;
      else
        reg_visible = 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  bpg_sync u_sync_high (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (high_port_in),
    .pin_sync (high_sync)
  ); // R17

  bpg_sync u_sync_low (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (low_port_in),
    .pin_sync (low_sync)
  ); // R17

  bpg_sync u_sync_ctl (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (control_port_in),
    .pin_sync (ctl_sync)
  ); // R17

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire       mode_exp = mode_reg[`BPG_MODE_EXP];
  wire       mode_per = mode_reg[`BPG_MODE_PER];
  wire       mode_emul = mode_reg[`BPG_MODE_EMUL];
  wire [7:0] idx      = paddr[`BPG_IDX_HI:`BPG_IDX_LO];
  wire       in_block = (paddr[`BPG_BASE_HI:`BPG_BASE_LO] == register_block_base) &&
                        (paddr[1:0] == 2'b00); // R15
  wire       visible  = reg_visible(idx, mode_exp, mode_per, mode_emul); // R6 R7 R8
  wire       known    = (idx <= `BPG_IDX_EXP_LAST) || (idx == `BPG_IDX_BASE);
  wire       hit      = in_block && known && visible;
  wire       removed  = in_block && known && !visible;
  wire       do_write = psel && penable && pready && pwrite && hit;

  // control pins taken by bus control functions
  wire [7:0] alt_mask = {control_pin_assignment[`BPG_PA_NOACC] & mode_exp,
                         control_pin_assignment[`BPG_PA_PIPE] & mode_exp,
                         control_pin_assignment[`BPG_PA_PIPE] & mode_exp,
                         ~control_pin_assignment[`BPG_PA_NOECK],
                         control_pin_assignment[`BPG_PA_LSTR] & mode_exp,
                         control_pin_assignment[`BPG_PA_RDW] & mode_exp,
                         2'b00}; // R11

  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (idx)
      `BPG_IDX_HIGH_DATA: next_rdata = port_read(high_port_direction, high_port_data, high_sync); // R2
      `BPG_IDX_LOW_DATA:  next_rdata = port_read(low_port_direction, low_port_data, low_sync); // R2
      `BPG_IDX_HIGH_DIR:  next_rdata = high_port_direction;
      `BPG_IDX_LOW_DIR:   next_rdata = low_port_direction;
      `BPG_IDX_CTL_DATA:  next_rdata = port_read(control_port_direction, control_port_data, ctl_sync); // R2 R10
      `BPG_IDX_CTL_DIR:   next_rdata = control_port_direction;
      `BPG_IDX_PIN_ASSGN: next_rdata = control_pin_assignment;
      `BPG_IDX_MODE:      next_rdata = mode_reg;
      `BPG_IDX_PULLUP:    next_rdata = pullup_reg;
      `BPG_IDX_BASE:      next_rdata = {2'b00, register_block_base};
      default:            next_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h00000000;
      ext_access <= 1'b0;
    end else begin
      pready     <= psel && penable && !pready;
      pslverr    <= psel && penable && !pready && !hit && !removed;
      ext_access <= psel && penable && !pready && removed; // R6 R7 R8
      if (psel && penable && !pready && !pwrite && hit)
        prdata <= {24'h000000, next_rdata};
      else
        prdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_port_data         <= `BPG_RST_DATA;
      low_port_data          <= `BPG_RST_DATA;
      high_port_direction    <= `BPG_RST_DIR; // R3
      low_port_direction     <= `BPG_RST_DIR; // R3
      control_port_data      <= `BPG_RST_DATA;
      control_port_direction <= `BPG_RST_DIR;
      control_pin_assignment <= `BPG_RST_PA;
      mode_reg               <= `BPG_RST_MODE;
      pullup_reg             <= `BPG_RST_PULLUP;
      register_block_base    <= `BPG_RST_BASE;
    end else if (do_write) begin
      case (idx)
        `BPG_IDX_HIGH_DATA: high_port_data <= pwdata[7:0];
        `BPG_IDX_LOW_DATA:  low_port_data <= pwdata[7:0];
        `BPG_IDX_HIGH_DIR:  high_port_direction <= pwdata[7:0];
        `BPG_IDX_LOW_DIR:   low_port_direction <= pwdata[7:0];
        `BPG_IDX_CTL_DATA:  control_port_data <= pwdata[7:0];
        `BPG_IDX_CTL_DIR:   control_port_direction <= pwdata[7:0] & ~`BPG_CTL_IN_ONLY; // R10
        `BPG_IDX_PIN_ASSGN: control_pin_assignment <= pwdata[7:0] & 8'hbc;
        `BPG_IDX_MODE:      mode_reg <= pwdata[7:0] & 8'h07;
        `BPG_IDX_PULLUP:    pullup_reg <= pwdata[7:0] & 8'h10;
        `BPG_IDX_BASE:      register_block_base <= pwdata[5:0]; // R15
        default:            mode_reg <= mode_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // pins 1-0 follow the interrupt inputs and never drive
  wire [7:0] ctl_in_only = `BPG_CTL_IN_ONLY; // R10

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_pins
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          high_port_oe[g]    <= 1'b0;
          low_port_oe[g]     <= 1'b0;
          control_port_oe[g] <= 1'b0;
        end else begin
          high_port_oe[g]    <= high_port_direction[g] & ~addr_data_bus_mode; // R1 R4
          low_port_oe[g]     <= low_port_direction[g] & ~addr_data_bus_mode; // R1 R5
          control_port_oe[g] <= control_port_direction[g] & ~alt_mask[g] &
                                ~ctl_in_only[g]; // R1 R9 R16
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_port_out      <= 8'h00;
      low_port_out       <= 8'h00;
      control_port_out   <= 8'h00;
      addr_data_bus_mode <= 1'b0;
      ctl_alt_select     <= 8'h00;
      ctl_pullup_en      <= 1'b0;
    end else begin
      high_port_out      <= high_port_data;
      low_port_out       <= low_port_data;
      control_port_out   <= control_port_data;
      addr_data_bus_mode <= mode_exp | mode_per; // R4 R5
      ctl_alt_select     <= alt_mask; // R11 R16
      ctl_pullup_en      <= pullup_reg[`BPG_PU_CTL]; // R12
    end
  end

endmodule

// ==== bpg_props.sv ====
module bpg_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [15:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        ext_access,
  input logic        addr_data_bus_mode,
  input logic [7:0]  control_port_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_home_low;
    paddr[15:10] == 6'h00 && paddr[1:0] == 2'h0 && paddr[9:2] < 8'h04;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  answer_next_a: assert property (s_taken |=> pready)
    else $error("no answer one cycle after access");
  pulse_once_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  answer_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  misalign_err_a: assert property (s_taken ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  hide_bus_a: assert property (s_taken ##0 s_home_low ##0 addr_data_bus_mode |=> ext_access && prdata == 32'h0)
    else $error("bus port register not removed");
  err_excl_a: assert property (ext_access |-> pready && !pslverr)
    else $error("external flag outside answer");
  irq_input_a: assert property (control_port_oe[1:0] == 2'h0)
    else $error("interrupt pin driven");
endmodule

// ==== bpg_pins.sv ====
module bpg_pins (
  input  logic [7:0] high_port_out,
  input  logic [7:0] high_port_oe,
  input  logic [7:0] low_port_out,
  input  logic [7:0] low_port_oe,
  input  logic [7:0] control_port_out,
  input  logic [7:0] control_port_oe,
  input  logic [23:0] ext_lvl,
  output logic [7:0] high_port_in,
  output logic [7:0] low_port_in,
  output logic [7:0] control_port_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin shows device level where driven, outside circuit level otherwise
  assign high_port_in = (high_port_oe & high_port_out) | (~high_port_oe & ext_lvl[7:0]);
  assign low_port_in = (low_port_oe & low_port_out) | (~low_port_oe & ext_lvl[15:8]);
  assign control_port_in = (control_port_oe & control_port_out) | (~control_port_oe & ext_lvl[23:16]);
endmodule

// ==== bpg_top_tb.sv ====
`include "bpg_regs.vh"
module bpg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_access;
  logic        addr_data_bus_mode, ctl_pullup_en;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  ctl_alt_select, high_port_in, high_port_out, high_port_oe, low_port_in, low_port_out;
  logic [7:0]  low_port_oe, control_port_in, control_port_out, control_port_oe, rd, m;
  logic [23:0] ext_lvl, oes, outs;
  logic        err, ext;
  logic [5:0]  base;
  int          num_errors, checked;
  logic [7:0]  didx [3] = '{`BPG_IDX_HIGH_DATA, `BPG_IDX_LOW_DATA, `BPG_IDX_CTL_DATA};
  logic [7:0]  ridx [3] = '{`BPG_IDX_HIGH_DIR, `BPG_IDX_LOW_DIR, `BPG_IDX_CTL_DIR};
  assign oes = {control_port_oe, low_port_oe, high_port_oe};
  assign outs = {control_port_out, low_port_out, high_port_out};
  bpg_top dut_u (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .ext_access         (ext_access),
    .addr_data_bus_mode (addr_data_bus_mode),
    .ctl_alt_select     (ctl_alt_select),
    .ctl_pullup_en      (ctl_pullup_en),
    .high_port_in       (high_port_in),
    .high_port_out      (high_port_out),
    .high_port_oe       (high_port_oe),
    .low_port_in        (low_port_in),
    .low_port_out       (low_port_out),
    .low_port_oe        (low_port_oe),
    .control_port_in    (control_port_in),
    .control_port_out   (control_port_out),
    .control_port_oe    (control_port_oe)
  );
  bpg_pins pins_u (
    .high_port_out    (high_port_out),
    .high_port_oe     (high_port_oe),
    .low_port_out     (low_port_out),
    .low_port_oe      (low_port_oe),
    .control_port_out (control_port_out),
    .control_port_oe  (control_port_oe),
    .ext_lvl          (ext_lvl),
    .high_port_in     (high_port_in),
    .low_port_in      (low_port_in),
    .control_port_in  (control_port_in)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic [1:0] lo = 2'h0);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {base, idx, lo};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      report_and_stop;
    end
    rd = prdata[7:0];
    err = pslverr;
    ext = ext_access;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    base = 6'h00;
    ext_lvl = 24'h5ac33c;
    num_errors = 0;
    checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, `BPG_IDX_HIGH_DIR, 8'h00);
    check(rd, 8'h00);
    xfer(1'b0, `BPG_IDX_LOW_DIR, 8'h00);
    check(rd, 8'h00);
    xfer(1'b0, 8'h20, 8'h00);
    check(err, 1'b1);
    xfer(1'b0, `BPG_IDX_HIGH_DATA, 8'h00, 2'h2);
    check(err, 1'b1);
    for (int i = 0; i < 3; i++) begin
      m = (i == 2) ? 8'hf0 : 8'hf3;
      xfer(1'b1, didx[i], 8'ha5);
      xfer(1'b1, ridx[i], 8'hf3);
      repeat (2) @(posedge pclk);
      xfer(1'b0, didx[i], 8'h00);
      check(rd, (8'ha5 & m) | (ext_lvl[8*i +: 8] & ~m));
      check(oes[8*i +: 8], m);
      check(outs[8*i +: 8], 8'ha5);
      xfer(1'b0, ridx[i], 8'h00);
      check(rd, m);
    end
    xfer(1'b1, `BPG_IDX_BASE, 8'h01);
    base = 6'h01;
    xfer(1'b0, `BPG_IDX_HIGH_DIR, 8'h00);
    check(rd, 8'hf3);
    base = 6'h00;
    xfer(1'b0, `BPG_IDX_HIGH_DIR, 8'h00);
    check(err, 1'b1);
    base = 6'h01;
    xfer(1'b1, `BPG_IDX_BASE, 8'h00);
    base = 6'h00;
    xfer(1'b1, `BPG_IDX_PIN_ASSGN, 8'h00);
    @(posedge pclk);
    check(ctl_alt_select, 8'h10);
    check(control_port_oe, 8'he0);
    xfer(1'b1, `BPG_IDX_PULLUP, 8'h10);
    @(posedge pclk);
    check(ctl_pullup_en, 1'b1);
    xfer(1'b1, `BPG_IDX_MODE, 8'h02);
    @(posedge pclk);
    check(addr_data_bus_mode, 1'b1);
    xfer(1'b0, `BPG_IDX_HIGH_DATA, 8'h00);
    check({ext, err, rd}, 10'h200);
    check(high_port_oe, 8'h00);
    check(low_port_oe, 8'h00);
    xfer(1'b1, `BPG_IDX_LOW_DIR, 8'hff);
    check({ext, err}, 2'h2);
    xfer(1'b0, `BPG_IDX_CTL_DATA, 8'h00);
    check(ext, 1'b0);
    xfer(1'b1, `BPG_IDX_MODE, 8'h03);
    xfer(1'b0, `BPG_IDX_CTL_DIR, 8'h00);
    check(ext, 1'b1);
    xfer(1'b1, `BPG_IDX_MODE, 8'h00);
    xfer(1'b0, `BPG_IDX_LOW_DIR, 8'h00);
    check(rd, 8'hf3);
    xfer(1'b1, `BPG_IDX_MODE, 8'h04);
    xfer(1'b0, `BPG_IDX_CTL_DATA, 8'h00);
    check(ext, 1'b1);
    xfer(1'b0, `BPG_IDX_EXP_LAST, 8'h00);
    check({ext, err}, 2'h2);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, `BPG_IDX_LOW_DIR, 8'h00);
    check(rd, 8'h00);
    report_and_stop;
  end
endmodule
bind bpg_top bpg_props chk_u (
  .pclk               (pclk),
  .presetn            (presetn),
  .psel               (psel),
  .penable            (penable),
  .paddr              (paddr),
  .prdata             (prdata),
  .pready             (pready),
  .pslverr            (pslverr),
  .ext_access         (ext_access),
  .addr_data_bus_mode (addr_data_bus_mode),
  .control_port_oe    (control_port_oe)
);
